/* File: sbc_pkg.sv */
`default_nettype none
package sbc_pkg;
	// Board clock and link framing
	localparam int unsigned SBC_CLK_HZ = 100_000_000;
	localparam int unsigned SBC_BAUD = 4800;
	localparam int unsigned SBC_CNT_W = 16;
	localparam int unsigned SBC_BYTE_W = 8;
	localparam int unsigned SBC_WORD_W = 24;
	localparam int unsigned SBC_FRAME_W = 10;
	localparam logic [3:0] SBC_FRAME_BITS = 4'hA;
	localparam logic [3:0] SBC_DATA_BITS = 4'h8;
	localparam logic [3:0] SBC_LAST_DATA_BIT = 4'h1;

	// Byte counts of a transfer: code plus three data bytes to write, code alone to read
	localparam logic [2:0] SBC_WR_BYTES = 3'h4;
	localparam logic [2:0] SBC_RD_BYTES = 3'h1;
	localparam logic [1:0] SBC_RX_LAST = 2'h2;
	localparam int unsigned SBC_CMD_WRITE_BIT = 7;

	// Command codes, read and write
	localparam logic [7:0] SBC_RD_RESULT = 8'h50;
	localparam logic [7:0] SBC_RD_CFG = 8'h51;
	localparam logic [7:0] SBC_WR_CFG = 8'hD1;
	localparam logic [7:0] SBC_RD_GAIN = 8'h52;
	localparam logic [7:0] SBC_WR_GAIN = 8'hD2;
	localparam logic [7:0] SBC_RD_DAC = 8'h53;
	localparam logic [7:0] SBC_WR_DAC = 8'hD3;
	localparam logic [7:0] SBC_RD_SIG_ROFF = 8'h54;
	localparam logic [7:0] SBC_WR_SIG_ROFF = 8'hD4;
	localparam logic [7:0] SBC_RD_SIG_NOFF = 8'h55;
	localparam logic [7:0] SBC_WR_SIG_NOFF = 8'hD5;
	localparam logic [7:0] SBC_RD_REF_NOFF = 8'h56;
	localparam logic [7:0] SBC_WR_REF_NOFF = 8'hD6;

	// Calibration control bits in the configuration word
	localparam int unsigned SBC_CAL_REF_NR = 7;
	localparam int unsigned SBC_CAL_SIG_NR = 6;
	localparam int unsigned SBC_CAL_SIG_RO = 5;
	localparam int unsigned SBC_CAL_GAIN = 4;
	localparam logic [1:0] SBC_PH_NR = 2'h0;
	localparam logic [1:0] SBC_PH_RO = 2'h1;
	localparam logic [1:0] SBC_PH_GAIN = 2'h2;

	// Response buffer depth
	localparam logic [1:0] SBC_BUF_DEPTH = 2'h2;

	typedef enum logic [2:0] {
		SBC_S_IDLE = 3'h0,
		SBC_S_TX = 3'h1,
		SBC_S_RX = 3'h3,
		SBC_S_PUSH = 3'h2,
		SBC_S_CALW = 3'h6,
		SBC_S_CALP = 3'h7,
		SBC_S_CALC = 3'h5
	} sbc_seq_t;

	typedef enum logic [1:0] {
		SBC_R_IDLE = 2'h0,
		SBC_R_START = 2'h1,
		SBC_R_DATA = 2'h3,
		SBC_R_STOP = 2'h2
	} sbc_rx_t;

	typedef struct packed {
		sbc_seq_t seq;
		logic [7:0] code;
		logic [23:0] data;
		logic [31:0] out;
		logic [2:0] nbytes;
		logic [1:0] rx_n;
		logic from_cal;
		logic [1:0] phase;
		logic [23:0] cal_cfg;
		logic [9:0] tx_sh;
		logic [3:0] tx_bits;
		logic [15:0] tx_cnt;
		logic txd;
		sbc_rx_t rx_st;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bits;
		logic [7:0] rx_sh;
		logic rx_v;
		logic [7:0] rx_byte;
		logic [23:0] buf0;
		logic [23:0] buf1;
		logic [1:0] fill;
		logic rsp_valid;
		logic cmd_ready;
		logic cal_busy;
	} sbc_state_t;
endpackage
`default_nettype wire

/* File: sbc_bridge_host.sv */
// Behaviour
// - Link is 4800 baud, 8N1, both ways
// - Each command opens with code byte, LSB first
// - Write code is followed by three data bytes
// - Data bytes go low byte first, LSB first
// - 50 reads result, 51/D1 configuration
// - 52/D2 gain, 53/D3 offset DAC
// - 54/D4 signal channel ratiometric offset
// - 55/D5 signal channel nonratiometric offset
// - 56/D6 reference channel nonratiometric offset
// - Nonratiometric calibrations run before all others
// - Both nonratiometric calibrations in one request
// - Then signal channel ratiometric offset calibration
// - Gain calibration last, then conversions
// - Each step started by configuration control bits
// - Bridge clocked from the board clock
`timescale 1ns/1ns
`default_nettype none
module sbc_bridge_host
	import sbc_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = SBC_CLK_HZ / SBC_BAUD
)
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	// Command request
	input wire logic cmd_valid,
	output var logic cmd_ready,
	input wire logic [7:0] cmd_code,
	input wire logic [23:0] cmd_data,
	// Calibration request
	input wire logic cal_start,
	input wire logic cal_nonratio,
	input wire logic [23:0] cal_config,
	output var logic cal_busy,
	// Read answers
	output var logic rsp_valid,
	input wire logic rsp_ready,
	output var logic [23:0] rsp_data,
	// Serial link
	output var logic txd,
	input wire logic rxd
);
	// Bit time in mclk cycles; the far side paces itself from its own
	// converter clock, so only the baud rate has to agree
	localparam logic [15:0] BIT_RELOAD = SBC_CNT_W'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF_RELOAD = SBC_CNT_W'(BIT_CYCLES / 2);

	sbc_state_t s;
	sbc_state_t next_s;

	// Control bits that start the given calibration phase
	function automatic logic [23:0] sbc_cal_bits(input logic [1:0] ph);
		logic [23:0] b;
		b = '0;
		unique case (ph)
			SBC_PH_NR:
			begin
				b[SBC_CAL_REF_NR] = 1'b1;
				b[SBC_CAL_SIG_NR] = 1'b1;
			end
			SBC_PH_RO:
				b[SBC_CAL_SIG_RO] = 1'b1;
			default:
				b[SBC_CAL_GAIN] = 1'b1;
		endcase
		return b;
	endfunction

	// Bit 7 splits each code pair into read and write; codes outside the
	// table are sent as given and treated by that bit alone
	function automatic logic sbc_is_write(input logic [7:0] code);
		return code[SBC_CMD_WRITE_BIT];
	endfunction

	// Next state of the whole bridge host
	always_comb
	begin
		logic pop;
		logic push;
		logic go;
		logic [23:0] word;
		pop = 1'b0;
		push = 1'b0;
		go = 1'b0;
		word = '0;
		next_s = s;
		next_s.rx_v = 1'b0;

		// Transmit engine: start, 8 data bits LSB first, stop
		// The shifter refills with ones, so the line rests high after a stop
		if (s.tx_bits != 4'h0)
		begin
			if (s.tx_cnt == 16'h0000)
			begin
				next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
				next_s.txd = s.tx_sh[1];
				next_s.tx_bits = s.tx_bits - 4'h1;
				next_s.tx_cnt = BIT_RELOAD;
			end
			else
				next_s.tx_cnt = s.tx_cnt - 16'h0001;
		end

		// Receive engine; a frame with a low stop bit is dropped
		// rxd is sampled as a synchronous input; a board pin needs its
		// own synchroniser in front of this port
		unique case (s.rx_st)
			SBC_R_IDLE:
				if (!rxd)
				begin
					next_s.rx_st = SBC_R_START;
					next_s.rx_cnt = HALF_RELOAD;
				end
			SBC_R_START:
				if (s.rx_cnt == 16'h0000)
				begin
					next_s.rx_cnt = BIT_RELOAD;
					next_s.rx_bits = SBC_DATA_BITS;
					// A glitch shorter than half a bit is not a start
					next_s.rx_st = rxd ? SBC_R_IDLE : SBC_R_DATA;
				end
				else
					next_s.rx_cnt = s.rx_cnt - 16'h0001;
			SBC_R_DATA:
				if (s.rx_cnt == 16'h0000)
				begin
					next_s.rx_sh = {rxd, s.rx_sh[7:1]};
					next_s.rx_bits = s.rx_bits - 4'h1;
					next_s.rx_cnt = BIT_RELOAD;
					if (s.rx_bits == SBC_LAST_DATA_BIT)
						next_s.rx_st = SBC_R_STOP;
				end
				else
					next_s.rx_cnt = s.rx_cnt - 16'h0001;
			SBC_R_STOP:
				if (s.rx_cnt == 16'h0000)
				begin
					next_s.rx_st = SBC_R_IDLE;
					if (rxd)
					begin
						next_s.rx_v = 1'b1;
						next_s.rx_byte = s.rx_sh;
					end
				end
				else
					next_s.rx_cnt = s.rx_cnt - 16'h0001;
		endcase

		// Command sequencer
		unique case (s.seq)
			SBC_S_IDLE:
				if (cal_start && !s.cal_busy)
				begin
					next_s.cal_busy = 1'b1;
					next_s.cal_cfg = cal_config;
					// Nonratiometric step, if used, goes first
					next_s.phase = cal_nonratio ? SBC_PH_NR : SBC_PH_RO;
					next_s.seq = SBC_S_CALW;
				end
				// Calibration wins over a user command in the same cycle
				else if (cmd_valid && s.cmd_ready)
				begin
					next_s.code = cmd_code;
					next_s.data = cmd_data;
					next_s.from_cal = 1'b0;
					go = 1'b1;
				end
			SBC_S_CALW:
			begin
				next_s.code = SBC_WR_CFG;
				next_s.data = s.cal_cfg | sbc_cal_bits(s.phase);
				next_s.from_cal = 1'b1;
				go = 1'b1;
			end
			SBC_S_CALP:
			begin
				// Poll the configuration word until the step bits clear
				next_s.code = SBC_RD_CFG;
				next_s.from_cal = 1'b1;
				go = 1'b1;
			end
			SBC_S_TX:
				if (s.tx_bits == 4'h0)
				begin
					if (s.nbytes != 3'h0)
					begin
						// Code byte leaves first, then data low byte first
						next_s.tx_sh = {1'b1, s.out[7:0], 1'b0};
						next_s.out = {8'h00, s.out[31:8]};
						next_s.nbytes = s.nbytes - 3'h1;
						next_s.tx_bits = SBC_FRAME_BITS;
						next_s.tx_cnt = BIT_RELOAD;
						next_s.txd = 1'b0;
					end
					else if (!sbc_is_write(s.code))
					begin
						// Read codes go out alone; the answer is collected in RX
						next_s.rx_n = 2'h0;
						next_s.data = '0;
						next_s.seq = SBC_S_RX;
					end
					else
						next_s.seq = s.from_cal ? SBC_S_CALP : SBC_S_IDLE;
				end
			SBC_S_RX:
				if (s.rx_v)
				begin
					// Answer bytes arrive low byte first
					next_s.data = {s.rx_byte, s.data[23:8]};
					next_s.rx_n = s.rx_n + 2'h1;
					if (s.rx_n == SBC_RX_LAST)
						next_s.seq = s.from_cal ? SBC_S_CALC : SBC_S_PUSH;
				end
			SBC_S_PUSH:
				// Stall rather than drop an answer; cmd_ready stays low
				if (s.fill != SBC_BUF_DEPTH || (s.rsp_valid && rsp_ready))
				begin
					push = 1'b1;
					word = s.data;
					next_s.seq = SBC_S_IDLE;
				end
			SBC_S_CALC:
				// No timeout: a step that never clears keeps cal_busy set
				// until reset, which is the only way out
				if ((s.data & sbc_cal_bits(s.phase)) != 24'h000000)
					next_s.seq = SBC_S_CALP;
				else if (s.phase == SBC_PH_GAIN)
				begin
					// Gain step done last; conversions may start
					next_s.cal_busy = 1'b0;
					next_s.seq = SBC_S_IDLE;
				end
				else
				begin
					// Nonratiometric, then ratiometric offset, then gain
					next_s.phase = s.phase + 2'h1;
					next_s.seq = SBC_S_CALW;
				end
			default:
				next_s.seq = SBC_S_IDLE;
		endcase

		// Launch a transfer; read codes send the code byte only
		// Data bytes follow the code byte, low byte first
		if (go)
		begin
			next_s.out = {next_s.data, next_s.code};
			next_s.nbytes = sbc_is_write(next_s.code) ? SBC_WR_BYTES
				: SBC_RD_BYTES;
			next_s.seq = SBC_S_TX;
		end

		// Two-entry answer buffer; pop before push so a full one can swap
		// A push into an empty buffer lands in buf0, else in buf1
		pop = s.rsp_valid && rsp_ready;
		if (pop)
		begin
			next_s.buf0 = s.buf1;
			next_s.fill = s.fill - 2'h1;
		end
		if (push)
		begin
			if (next_s.fill == 2'h0)
				next_s.buf0 = word;
			else
				next_s.buf1 = word;
			next_s.fill = next_s.fill + 2'h1;
		end
		next_s.rsp_valid = next_s.fill != 2'h0;

		// Accept user commands only when idle and not calibrating
		next_s.cmd_ready = next_s.seq == SBC_S_IDLE && !next_s.cal_busy
			&& !(cal_start && !s.cal_busy && s.seq == SBC_S_IDLE);
	end

	// State register; the line idles high from reset
	// Reset acts without clk_en, so a frozen bridge can still be cleared
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.txd <= 1'b1;
		end
		else if (clk_en)
			s <= next_s;
	end

	// Outputs straight from the state register
	// rsp_data shows the buffer head even while rsp_valid is low
	assign cmd_ready = s.cmd_ready;
	assign cal_busy = s.cal_busy;
	assign rsp_valid = s.rsp_valid;
	assign rsp_data = s.buf0;
	assign txd = s.txd;
endmodule
`default_nettype wire

/* File: sbc_bridge_host_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module sbc_bridge_host_assertions
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Requests
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cal_start,
	input wire logic cal_busy,
	// Answers and line
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [23:0] rsp_data,
	input wire logic txd
);
	// One domain, so one clocking and one disable
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire logic take = clk_en && cmd_valid && cmd_ready && !cal_start;

	// Latency kept loose by a cycle: ready is registered
	a_take_busy: assert property (take |=> ##[0:1] !cmd_ready)
		else $error("ready stayed after take");
	a_start_low: assert property (take |=> ##[0:2] !txd)
		else $error("no start bit");
	a_idle_high: assert property (cmd_ready |-> txd)
		else $error("line not idle high");
	a_bit_width: assert property ($fell(txd) |-> !txd [*4])
		else $error("bit too short");
	a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
		rsp_valid && $stable(rsp_data))
		else $error("answer lost");
	a_rsp_cause: assert property ($rose(rsp_valid) |->
		!$past(cmd_ready))
		else $error("answer without read");
	a_cal_take: assert property (cal_start && cmd_ready &&
		!cal_busy && clk_en |=> ##[0:1] cal_busy)
		else $error("calibration not taken");
	a_cal_refuse: assert property (cal_busy [*2] |=>
		!cmd_ready || !cal_busy)
		else $error("ready during calibration");
endmodule
bind sbc_bridge_host sbc_bridge_host_assertions u_chk (.mclk, .resetn,
	.clk_en, .cmd_valid, .cmd_ready, .cal_start, .cal_busy, .rsp_valid,
	.rsp_ready, .rsp_data, .txd);
`default_nettype wire

/* File: sbc_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sbc_dev_model
#(
	parameter int BIT = 8,
	// Converter clocks per result word: 4 MHz at 50 words a second
	parameter int WORD = 80000
)
(
	// Clock shared with the bridge, and pace
	input wire logic mclk,
	input wire logic slow,
	// Serial lines, idle high
	input wire logic line_in,
	output var logic line_out
);
	logic [23:0] r [0:7];
	logic [23:0] h [$];
	logic [7:0] c;
	logic [7:0] b;
	int k;
	int conv_t;
	// Mid-bit sampling after the start edge
	task automatic get(output logic [7:0] v);
		@(negedge line_in);
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge mclk);
			v[i] = line_in;
		end
		repeat (BIT) @(posedge mclk);
	endtask
	// Start 0, data LSB first, stop 1
	task automatic put(input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			line_out <= f[i];
			repeat (BIT) @(posedge mclk);
		end
	endtask
	// A fresh result word each WORD clocks; zero, as no reference is wired
	always @(posedge mclk)
	begin
		conv_t <= (conv_t == WORD - 1) ? 0 : conv_t + 1;
		if (conv_t == 0)
			r[0] <= 24'h000000;
	end
	// Result reads zero: no reference is wired here
	initial
	begin
		line_out = 1'b1;
		k = 0;
		foreach (r[i]) r[i] = 24'h000000;
		forever
		begin
			get(c);
			if (c[7])
			begin
				for (int j = 0; j < 24; j += 8)
				begin
					get(b);
					r[c[2:0]][j +: 8] = b;
				end
				if (c == 8'hD1)
					h.push_back(r[1] & 24'h0000F0);
				if (c == 8'hD1 && r[1][7:4] != 4'h0)
					k = 2;
			end
			else
			begin
				// Waits at least one bit so the stop bit ends first
				repeat (BIT * (slow ? 6 : 1)) @(posedge mclk);
				if (c == 8'h51 && k == 1)
					r[1][7:4] = 4'h0;
				k = (c == 8'h51 && k > 0) ? k - 1 : k;
				for (int j = 0; j < 24; j += 8)
					put(r[c[2:0]][j +: 8]);
			end
		end
	end
endmodule
`default_nettype wire

/* File: test_serial_register_command_bridge.sv */
`timescale 1ns/1ns
`default_nettype none
module test_serial_register_command_bridge;
	localparam int BITC = 8;
	logic mclk, resetn, cmd_valid, cmd_ready, cal_start, cal_nonratio;
	logic cal_busy, rsp_valid, rsp_ready, txd, rxd, slow, clk_en;
	logic [7:0] cmd_code;
	logic [23:0] cmd_data, cal_config, rsp_data, d [1:6];
	int err_count, n_compared, n;
	sbc_bridge_host #(.BIT_CYCLES(BITC)) u_dut (.mclk, .resetn,
		.clk_en, .cmd_valid, .cmd_ready, .cmd_code, .cmd_data,
		.cal_start, .cal_nonratio, .cal_config, .cal_busy, .rsp_valid,
		.rsp_ready, .rsp_data, .txd, .rxd);
	sbc_dev_model #(.BIT(BITC)) u_dev (.mclk, .slow, .line_in(txd),
		.line_out(rxd));
	// Free-running clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Control bits expected in the first calibration write
	function automatic logic [23:0] first_cal(input int nr);
		return nr ? 24'h0000C0 : 24'h000020;
	endfunction
	// Bounded wait on a settled flag: 0 ready, 1 answer, 2 cal done
	task automatic wt(input int s);
		for (n = 0; n < 5000; n++)
		begin
			if ((s == 0 ? cmd_ready : s == 1 ? rsp_valid : !cal_busy) === 1'b1)
				break;
			@(negedge mclk);
		end
		if (n == 5000)
		begin
			err_count++;
			$display("BAD %0t wait %0d ran out", $time, s);
		end
	endtask
	// Held until a sampled ready, then dropped
	task automatic cmd(input logic [7:0] c, input logic [23:0] v);
		cmd_code = c;
		cmd_data = v;
		cmd_valid = 1'b1;
		wt(0);
		@(negedge mclk);
		cmd_valid = 1'b0;
		@(negedge mclk);
	endtask
	task automatic pop(input logic [23:0] e);
		wt(1);
		chk(rsp_data, e);
		rsp_ready = 1'b1;
		@(negedge mclk);
		rsp_ready = 1'b0;
		@(negedge mclk);
	endtask
	task automatic stop_test();
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (60000) @(posedge mclk);
		err_count++;
		stop_test();
	end
	// Main sequence
	initial
	begin
		{cmd_valid, cal_start, cal_nonratio, rsp_ready, slow} = 5'h00;
		clk_en = 1'b1;
		{cmd_code, cmd_data, cal_config} = 56'h0;
		{err_count, n_compared} = 64'h0;
		resetn = 1'b0;
		n = $urandom(18275);
		repeat (6) @(negedge mclk);
		resetn = 1'b1;
		@(negedge mclk);
		// Writes, cal bits kept clear so nothing starts
		for (int i = 1; i < 7; i++)
		begin
			d[i] = (i == 2) ? 24'h800001 : 24'($urandom()) & 24'hFFFF0F;
			cmd({5'h1A, 3'(i)}, d[i]);
			wt(0);
			chk(u_dev.r[i], d[i]);
		end
		// Reads back to back, result register included
		for (int i = 0; i < 7; i++)
		begin
			cmd({5'h0A, 3'(i)}, 24'($urandom()));
			pop(i == 0 ? 24'h000000 : d[i]);
			wt(0);
		end
		// Slow far side, nobody pops: third answer must stall
		slow = 1'b1;
		for (int i = 1; i < 4; i++)
			cmd({5'h0A, 3'(i)}, 24'h000000);
		repeat (1000) @(negedge mclk);
		chk(24'(cmd_ready), 24'h000000);
		for (int i = 1; i < 4; i++)
			pop(d[i]);
		wt(0);
		slow = 1'b0;
		// Frozen bridge: a calibration request must not be taken
		clk_en = 1'b0;
		cal_start = 1'b1;
		repeat (3) @(negedge mclk);
		chk(24'(cal_busy), 24'h000000);
		cal_start = 1'b0;
		clk_en = 1'b1;
		@(negedge mclk);
		// Calibration with and without the nonratiometric step
		for (int nr = 1; nr >= 0; nr--)
		begin
			cal_config = 24'($urandom()) & 24'hFFFF0F;
			cal_nonratio = 1'(nr);
			u_dev.h.delete();
			cal_start = 1'b1;
			@(negedge mclk);
			cal_start = 1'b0;
			@(negedge mclk);
			wt(2);
			chk(u_dev.r[1], cal_config);
			chk(24'(u_dev.h.size()), 24'(nr ? 3 : 2));
			chk(u_dev.h[0], first_cal(nr));
			if (nr)
				chk(u_dev.h[1], 24'h000020);
			chk(u_dev.h[u_dev.h.size() - 1], 24'h10);
		end
		stop_test();
	end
endmodule
`default_nettype wire
